/* alu_core.sv */
// Combinational arithmetic, logic and bit datapath of the execution core
`timescale 1ns/1ns
module alu_core (
  // Operation and operands
  input  wire mcu_exec_pkg::op_e        op,
  input  wire logic [7:0]               acc,
  input  wire logic [7:0]               fval,
  input  wire logic [7:0]               literal,
  input  wire logic [2:0]               bitsel,
  // Results
  output      logic [7:0]               result,
  output      mcu_exec_pkg::alu_flags_s flags,
  output      logic                     bit_is_set
);
  import mcu_exec_pkg::*;

  logic [7:0] operand;
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] bit_mask;

  // Literal forms take the immediate, file forms the register value
  assign operand  = (op == OP_ADD_LIT || op == OP_AND_LIT) ? literal : fval;
  assign sum      = {1'b0, acc} + {1'b0, operand};
  assign low_sum  = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};
  assign bit_mask = 8'h01 << bitsel;
  assign bit_is_set = |(fval & bit_mask);

  // Result and flag selection per operation
  always_comb begin
    result = fval;
    case (op)
      OP_ADD_LIT,
      OP_ADD_FILE: result = sum[7:0];
      OP_AND_LIT,
      OP_AND_FILE: result = acc & operand;
      OP_CLR_BIT:  result = fval & ~bit_mask;
      OP_SET_BIT:  result = fval | bit_mask;
      default:     result = fval;
    endcase
    flags.carry      = sum[8];
    flags.half_carry = low_sum[4];
    flags.zero       = (result == 8'h00);
  end

endmodule

/* mcu_alu_bit_ops_exec.sv */
// Execution core for add, AND, bit and watchdog-clear instructions
//
// Local design decisions: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
module mcu_alu_bit_ops_exec #(
  parameter int          PRESC_W   = 7,
  parameter logic [6:0]  PORT_ADDR = 7'h05
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Avalon-MM slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output      logic [31:0] readdata,
  output      logic        waitrequest,
  // Port pins
  input  wire logic [7:0]  port_pins_in,
  output      logic [7:0]  port_out,
  // Watchdog
  output      logic        wdt_timeout
);
  import mcu_exec_pkg::*;

  // ***********************************************************************
  // Storage and state
  // ***********************************************************************
  logic [7:0]         file_mem [0:127];
  state_e             state_reg;
  state_e             state_next;
  logic [13:0]        ir_reg;
  logic [12:0]        pc_reg;
  logic               skip_pending_reg;
  logic               skip_pending_next;
  logic [7:0]         acc_reg;
  logic               carry_reg;
  logic               half_carry_reg;
  logic               zero_reg;
  logic               expired_reg;
  logic               sleep_reg;
  logic [6:0]         faddr_reg;
  logic               wdt_en_reg;
  logic [PRESC_W-1:0] presc_reg;
  logic [7:0]         wdt_count_reg;
  logic               wdt_timeout_reg;
  logic [7:0]         port_latch_reg;
  logic [31:0]        readdata_reg;
  logic               rd_valid_reg;

  // ***********************************************************************
  // Decode and datapath
  // ***********************************************************************
  instr_s     ir;
  logic [7:0] exec_fval;
  logic [7:0] alu_result;
  alu_flags_s alu_flags;
  logic       alu_bit;
  logic       executing;
  logic       skip_taken;
  logic       wr_file;
  logic       wr_acc;
  logic       wdt_clear;
  logic       wdt_tick;
  logic       wdt_wrap;

  assign ir = decode_instr(ir_reg);

  // File operand; the port address reads its pins, not the latch
  function automatic logic [7:0] file_read(input logic [6:0] a,
                                            input logic [7:0] pins,
                                            input logic [7:0] stored);
    return (a == PORT_ADDR) ? pins : stored;
  endfunction

  assign exec_fval = file_read(ir.faddr, port_pins_in,
                               file_mem[ir.faddr]);

  alu_core u_alu (
    .op         (ir.op),
    .acc        (acc_reg),
    .fval       (exec_fval),
    .literal    (ir.literal),
    .bitsel     (ir.bitsel),
    .result     (alu_result),
    .flags      (alu_flags),
    .bit_is_set (alu_bit)
  );

  // A discarded instruction runs as a no-op; only the program counter advances
  assign executing = (state_reg == ST_EXEC) && !skip_pending_reg;

  // Skip tests that come out true
  assign skip_taken = executing &&
                      ((ir.op == OP_SKIP_CLR && !alu_bit) ||
                       (ir.op == OP_SKIP_SET &&  alu_bit));

  // Destination steering for file and literal operations
  always_comb begin
    wr_file = 1'b0;
    wr_acc  = 1'b0;
    if (executing) begin
      case (ir.op)
        OP_ADD_LIT,
        OP_AND_LIT:  wr_acc = 1'b1;
        OP_ADD_FILE,
        OP_AND_FILE: begin
          wr_file = ir.dest;
          wr_acc  = !ir.dest;
        end
        OP_CLR_BIT,
        OP_SET_BIT:  wr_file = 1'b1;
        default: begin
          wr_file = 1'b0;
          wr_acc  = 1'b0;
        end
      endcase
    end
  end

  assign wdt_clear = executing && (ir.op == OP_WDT_CLR);

  // ***********************************************************************
  // Avalon-MM slave
  // ***********************************************************************
  logic busy;
  logic rd_capture;
  logic wr_fire;

  // Reads need one cycle to register data; execution stalls the bus
  assign busy        = (state_reg != ST_IDLE);
  assign waitrequest = busy || (read && !rd_valid_reg);
  assign rd_capture  = read && !busy && !rd_valid_reg;
  assign wr_fire     = write && !waitrequest;
  assign readdata    = readdata_reg;

  // Read data register, unmapped offsets read as zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      readdata_reg <= 32'h0000_0000;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= rd_capture;
      if (rd_capture) begin
        case (address)
          OFS_ACC:    readdata_reg <= {24'h00_0000, acc_reg};
          OFS_STATUS: readdata_reg <= {27'h000_0000, expired_reg, sleep_reg,
                                       zero_reg, half_carry_reg, carry_reg};
          OFS_FADDR:  readdata_reg <= {25'h000_0000, faddr_reg};
          OFS_FDATA:  readdata_reg <= {24'h00_0000,
                                       file_read(faddr_reg, port_pins_in,
                                                 file_mem[faddr_reg])};
          OFS_PC:     readdata_reg <= {19'h0_0000, pc_reg};
          OFS_WDT:    readdata_reg <= {24'h00_0000, wdt_count_reg};
          OFS_CTRL:   readdata_reg <= {31'h0000_0000, wdt_en_reg};
          default:    readdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Software-held configuration
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      faddr_reg  <= 7'h00;
      wdt_en_reg <= WDT_EN_RST;
    end else if (wr_fire) begin
      if (address == OFS_FADDR)
        faddr_reg <= writedata[6:0];
      if (address == OFS_CTRL)
        wdt_en_reg <= writedata[CTRL_WDT_EN];
    end
  end

  // ***********************************************************************
  // Sequencing
  // ***********************************************************************
  always_comb begin
    state_next        = state_reg;
    skip_pending_next = skip_pending_reg;
    case (state_reg)
      ST_IDLE: begin
        if (wr_fire && address == OFS_INSTR)
          state_next = ST_EXEC;
      end
      ST_EXEC: begin
        // A discarded slot is consumed here and releases the skip
        skip_pending_next = skip_taken;
        state_next = skip_taken ? ST_NOP : ST_IDLE;
      end
      ST_NOP:  state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // State, instruction register and program counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg        <= ST_IDLE;
      skip_pending_reg <= 1'b0;
      ir_reg           <= 14'h0000;
      pc_reg           <= PC_RST;
    end else begin
      state_reg        <= state_next;
      skip_pending_reg <= skip_pending_next;
      if (state_reg == ST_IDLE && wr_fire && address == OFS_INSTR)
        ir_reg <= writedata[13:0];
      if (state_reg == ST_EXEC)
        pc_reg <= pc_reg + 13'h0001;
    end
  end

  // ***********************************************************************
  // Accumulator and status flags
  // ***********************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_reg <= ACC_RST;
    end else if (wr_acc) begin
      acc_reg <= alu_result;
    end else if (wr_fire && address == OFS_ACC) begin
      acc_reg <= writedata[7:0];
    end
  end

  // Arithmetic flags; bit and skip operations leave them alone
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      carry_reg      <= STATUS_RST[ST_CARRY];
      half_carry_reg <= STATUS_RST[ST_HALF_CARRY];
      zero_reg       <= STATUS_RST[ST_ZERO];
    end else if (executing && (ir.op == OP_ADD_LIT ||
                               ir.op == OP_ADD_FILE)) begin
      carry_reg      <= alu_flags.carry;
      half_carry_reg <= alu_flags.half_carry;
      zero_reg       <= alu_flags.zero;
    end else if (executing && (ir.op == OP_AND_LIT ||
                               ir.op == OP_AND_FILE)) begin
      zero_reg       <= alu_flags.zero;
    end else if (wr_fire && address == OFS_STATUS) begin
      carry_reg      <= writedata[ST_CARRY];
      half_carry_reg <= writedata[ST_HALF_CARRY];
      zero_reg       <= writedata[ST_ZERO];
    end
  end

  // Watchdog-related flags; the clear instruction beats a timeout
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      expired_reg <= STATUS_RST[ST_EXPIRED];
      sleep_reg   <= STATUS_RST[ST_SLEEP];
    end else if (wdt_clear) begin
      expired_reg <= 1'b1;
      sleep_reg   <= 1'b1;
    end else if (wdt_wrap) begin
      expired_reg <= 1'b0;
    end
  end

  // ***********************************************************************
  // File registers and port latch
  // ***********************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 128; i++)
        file_mem[i] <= 8'h00;
    end else if (wr_file && ir.faddr != PORT_ADDR) begin
      file_mem[ir.faddr] <= alu_result;
    end else if (wr_fire && address == OFS_FDATA &&
                 faddr_reg != PORT_ADDR) begin
      file_mem[faddr_reg] <= writedata[7:0];
    end
  end

  // Writes to the port address land in its output latch
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      port_latch_reg <= 8'h00;
    end else if (wr_file && ir.faddr == PORT_ADDR) begin
      port_latch_reg <= alu_result;
    end else if (wr_fire && address == OFS_FDATA &&
                 faddr_reg == PORT_ADDR) begin
      port_latch_reg <= writedata[7:0];
    end
  end

  assign port_out = port_latch_reg;

  // ***********************************************************************
  // Watchdog counter and prescaler
  // ***********************************************************************
  assign wdt_tick = wdt_en_reg && (&presc_reg);
  assign wdt_wrap = wdt_tick && (&wdt_count_reg) && !wdt_clear;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      presc_reg       <= '0;
      wdt_count_reg   <= 8'h00;
      wdt_timeout_reg <= 1'b0;
    end else begin
      wdt_timeout_reg <= wdt_wrap;
      if (wdt_clear) begin
        presc_reg     <= '0;
        wdt_count_reg <= 8'h00;
      end else if (wdt_en_reg) begin
        presc_reg <= presc_reg + {{(PRESC_W-1){1'b0}}, 1'b1};
        if (wdt_tick)
          wdt_count_reg <= wdt_count_reg + 8'h01;
      end
    end
  end

  assign wdt_timeout = wdt_timeout_reg;

endmodule

/* mcu_alu_bit_ops_exec_properties.sv */
// Port-level properties of the execution core and their bind
`timescale 1ns/1ns
module mcu_exec_checker
  import mcu_exec_pkg::*;
#(
  parameter int         PRESC_W   = 7,
  parameter logic [6:0] PORT_ADDR = 7'h05
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // Avalon-MM slave
  input wire logic [4:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic        waitrequest,
  // Port and watchdog
  input wire logic [7:0]  port_pins_in,
  input wire logic [7:0]  port_out,
  input wire logic        wdt_timeout
);
  logic       wr_go;
  logic       rd_go;
  logic       instr_go;
  logic       prev_skip;
  logic       exec_q;
  logic [2:0] bit_q;
  logic [7:0] pins_q;

  // ************************
  // Helper logic
  // ************************
  // Accepted transfers
  assign wr_go    = write && !waitrequest;
  assign rd_go    = read && !waitrequest;
  assign instr_go = wr_go && address == OFS_INSTR;

  // Word in flight; a word after a skip test may be discarded
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_skip <= 1'b0;
      exec_q    <= 1'b0;
      bit_q     <= 3'h0;
      pins_q    <= 8'h00;
    end else begin
      exec_q <= instr_go;
      if (instr_go) begin
        prev_skip <= writedata[13:11] == 3'b011;
        bit_q     <= writedata[9:7];
      end
      if (exec_q)
        pins_q <= port_pins_in; // Pins seen in the execute cycle
    end
  end

  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // ************************
  // Properties
  // ************************
  a_exec_stall: assert property (instr_go ##1 read |-> waitrequest)
    else $error("read accepted while an instruction executes");
  a_exec_bound: assert property (
    instr_go ##1 read |-> ##[1:5] !waitrequest)
    else $error("instruction did not finish in time");
  a_write_after_read: assert property (
    $past(rd_go) && write |-> !waitrequest)
    else $error("write stalled with the core idle");
  a_port_set: assert property (
    instr_go && !prev_skip && writedata[13:10] == OPC_SET_BIT
    && writedata[6:0] == PORT_ADDR
    |-> ##2 port_out == (pins_q | (8'h01 << bit_q)))
    else $error("bit set on port gave a wrong latch");
  a_port_clear: assert property (
    instr_go && !prev_skip && writedata[13:10] == OPC_CLR_BIT
    && writedata[6:0] == PORT_ADDR
    |-> ##2 port_out == (pins_q & ~(8'h01 << bit_q)))
    else $error("bit clear on port gave a wrong latch");
  a_port_quiet: assert property (
    !$stable(port_out) |-> $past(wr_go) || $past(wr_go, 2))
    else $error("port latch changed with no write");
  a_timeout_pulse: assert property (
    wdt_timeout |=> !wdt_timeout [*8])
    else $error("watchdog timeout repeated too soon");
  a_clear_quiet: assert property (
    instr_go && !prev_skip && writedata[13:0] == OPC_WDT_CLR
    |-> ##3 !wdt_timeout [*8])
    else $error("watchdog timed out right after a clear");
endmodule

bind mcu_alu_bit_ops_exec mcu_exec_checker #(
  .PRESC_W   (PRESC_W),
  .PORT_ADDR (PORT_ADDR)
) mcu_exec_checker_inst (
  .clk          (clk),
  .rstn         (rstn),
  .address      (address),
  .read         (read),
  .write        (write),
  .writedata    (writedata),
  .waitrequest  (waitrequest),
  .port_pins_in (port_pins_in),
  .port_out     (port_out),
  .wdt_timeout  (wdt_timeout)
);

/* mcu_exec_pkg.sv */
// Constants, types and instruction decode for the ALU and bit execution core
// ***********************************************************************
// ***********************************************************************
package mcu_exec_pkg;

  // Avalon register byte offsets
  localparam logic [4:0] OFS_INSTR  = 5'h00;
  localparam logic [4:0] OFS_ACC    = 5'h04;
  localparam logic [4:0] OFS_STATUS = 5'h08;
  localparam logic [4:0] OFS_FADDR  = 5'h0c;
  localparam logic [4:0] OFS_FDATA  = 5'h10;
  localparam logic [4:0] OFS_PC     = 5'h14;
  localparam logic [4:0] OFS_WDT    = 5'h18;
  localparam logic [4:0] OFS_CTRL   = 5'h1c;

  // Status and control register field positions
  localparam int ST_CARRY      = 0;
  localparam int ST_HALF_CARRY = 1;
  localparam int ST_ZERO       = 2;
  localparam int ST_SLEEP      = 3;
  localparam int ST_EXPIRED    = 4;
  localparam int CTRL_WDT_EN   = 0;

  // Reset values
  localparam logic [4:0]  STATUS_RST = 5'h18;
  localparam logic [7:0]  ACC_RST    = 8'h00;
  localparam logic [12:0] PC_RST     = 13'h0000;
  localparam logic        WDT_EN_RST = 1'b0;

  // Opcode patterns
  localparam logic [5:0]  OPC_ADD_FILE = 6'h07;
  localparam logic [5:0]  OPC_AND_FILE = 6'h05;
  localparam logic [3:0]  OPC_CLR_BIT  = 4'h4;
  localparam logic [3:0]  OPC_SET_BIT  = 4'h5;
  localparam logic [3:0]  OPC_SKIP_CLR = 4'h6;
  localparam logic [3:0]  OPC_SKIP_SET = 4'h7;
  localparam logic [4:0]  OPC_ADD_LIT  = 5'h1f;
  localparam logic [5:0]  OPC_AND_LIT  = 6'h39;
  localparam logic [13:0] OPC_WDT_CLR  = 14'h0064;

  typedef enum logic [3:0] {
    OP_NOP      = 4'h0,
    OP_ADD_LIT  = 4'h1,
    OP_AND_LIT  = 4'h2,
    OP_ADD_FILE = 4'h3,
    OP_AND_FILE = 4'h4,
    OP_CLR_BIT  = 4'h5,
    OP_SET_BIT  = 4'h6,
    OP_SKIP_CLR = 4'h7,
    OP_SKIP_SET = 4'h8,
    OP_WDT_CLR  = 4'h9
  } op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_NOP  = 2'b10
  } state_e;

  typedef struct packed {
    op_e        op;
    logic       dest;
    logic [6:0] faddr;
    logic [2:0] bitsel;
    logic [7:0] literal;
  } instr_s;

  typedef struct packed {
    logic carry;
    logic half_carry;
    logic zero;
  } alu_flags_s;

  // Split a 14-bit instruction word into its operation and operands
  function automatic instr_s decode_instr(input logic [13:0] word);
    instr_s d;
    d.dest    = word[7];
    d.faddr   = word[6:0];
    d.bitsel  = word[9:7];
    d.literal = word[7:0];
    if (word[13:9] == OPC_ADD_LIT)
      d.op = OP_ADD_LIT;
    else if (word[13:8] == OPC_AND_LIT)
      d.op = OP_AND_LIT;
    else if (word[13:8] == OPC_ADD_FILE)
      d.op = OP_ADD_FILE;
    else if (word[13:8] == OPC_AND_FILE)
      d.op = OP_AND_FILE;
    else if (word[13:10] == OPC_CLR_BIT)
      d.op = OP_CLR_BIT;
    else if (word[13:10] == OPC_SET_BIT)
      d.op = OP_SET_BIT;
    else if (word[13:10] == OPC_SKIP_CLR)
      d.op = OP_SKIP_CLR;
    else if (word[13:10] == OPC_SKIP_SET)
      d.op = OP_SKIP_SET;
    else if (word == OPC_WDT_CLR)
      d.op = OP_WDT_CLR;
    else
      d.op = OP_NOP;
    return d;
  endfunction

endpackage

/* testbench.sv */
// Self-checking bench of the execution core through its register bus
`timescale 1ns/1ns
module testbench;
  import mcu_exec_pkg::*;
  localparam logic [6:0] PORT = 7'h05;
  localparam logic [13:0] PROG [26] = '{14'h3e01, 14'h3ef0, 14'h39ff,
    14'h3e81, 14'h0720, 14'h07a0, 14'h0520, 14'h05a0, 14'h17a0, 14'h10a0,
    14'h1820, 14'h3e55, 14'h1ba0, 14'h3e01, 14'h1fa0, 14'h3900, 14'h1f20,
    14'h3eff, 14'h1485, 14'h0785, 14'h1005, 14'h3e7f, 14'h1c7f, 14'h0064,
    14'h1820, 14'h1785};
  // Design signals
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [4:0]  address = 5'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [7:0]  port_pins_in = 8'h00;
  logic [7:0]  port_out;
  logic        wdt_timeout;
  // Reference state
  logic [7:0]  acc_m = 8'h00;
  logic [7:0]  port_m = 8'h00;
  logic [4:0]  st_m = 5'h18;
  logic [12:0] pc_m = 13'h0;
  logic        skip_m = 1'b0;
  logic [7:0]  mem [128];
  logic [31:0] q;
  int          err_count = 0;
  int          num_checks = 0;
  int          n;

  mcu_alu_bit_ops_exec #(
    .PRESC_W   (2),
    .PORT_ADDR (PORT)
  ) mcu_alu_bit_ops_exec_inst (
    .clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .port_pins_in(port_pins_in), .port_out(port_out),
    .wdt_timeout(wdt_timeout));

  // Clock
  always #5 clk = ~clk;

  // ************************
  // Tasks
  // ************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One transfer, held until waitrequest is seen low; request stays up
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    int k;
    address   <= a;
    writedata <= d;
    read      <= !w;
    write     <= w;
    k = 0;
    @(posedge clk);
    while (waitrequest !== 1'b0 && k < 40) begin
      k++;
      @(posedge clk);
    end
    q = readdata;
    if (k == 40) begin
      err_count++;
      report_and_stop();
    end
  endtask

  task automatic idle();
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  // Run one word on the model and the design, then compare state
  task automatic step(input logic [13:0] w);
    logic [6:0] f;
    logic [7:0] v;
    logic [7:0] o;
    logic [7:0] r;
    logic [8:0] s;
    logic [1:0] tgt;
    f = w[6:0];
    v = (f == PORT) ? port_pins_in : mem[f];
    o = w[13] ? w[7:0] : v;
    tgt = (w[13] || !w[7]) ? 2'd1 : 2'd2;
    r = 8'h00;
    pc_m++;
    if (skip_m) begin
      // A discarded word only advances the program counter
      skip_m = 1'b0;
      tgt    = 2'd0;
    end else if (w[13:9] == 5'h1f || w[13:8] == 6'h07) begin
      s = {1'b0, acc_m} + {1'b0, o};
      r = s[7:0];
      st_m[2:0] = {r == 8'h00, 5'(acc_m[3:0]) + 5'(o[3:0]) > 5'h0f, s[8]};
    end else if (w[13:8] == 6'h39 || w[13:8] == 6'h05) begin
      r = acc_m & o;
      st_m[2] = r == 8'h00;
    end else if (w[13:11] == 3'b010) begin
      r = w[10] ? v | (8'h01 << w[9:7]) : v & ~(8'h01 << w[9:7]);
      tgt = 2'd2;
    end else begin
      if (w[13:11] == 3'b011)
        skip_m = v[w[9:7]] == w[10];
      if (w == OPC_WDT_CLR)
        st_m[4:3] = 2'b11;
      tgt = 2'd0;
    end
    if (skip_m || tgt == 2'd0)
      tgt = 2'd0;
    else if (tgt == 2'd1)
      acc_m = r;
    else if (f == PORT)
      port_m = r;
    else
      mem[f] = r;
    bus(1'b1, OFS_INSTR, {18'h0, w});
    bus(1'b0, OFS_ACC, 32'h0);
    chk("acc", {24'h0, acc_m}, q);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("status", {27'h0, st_m}, q);
    bus(1'b0, OFS_PC, 32'h0);
    chk("pc", {19'h0, pc_m}, q);
    bus(1'b1, OFS_FADDR, {25'h0, f});
    bus(1'b0, OFS_FDATA, 32'h0);
    chk("file", {24'h0, f == PORT ? v : mem[f]}, q);
    chk("latch", {24'h0, port_m}, {24'h0, port_out});
  endtask

  // ************************
  // Main sequence
  // ************************
  initial begin
    foreach (mem[i])
      mem[i] = 8'h00;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("status reset", 32'h18, q);
    bus(1'b1, OFS_STATUS, 32'hff);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("status write", 32'h1f, q);
    bus(1'b1, OFS_STATUS, 32'h0);
    bus(1'b1, OFS_PC, 32'h1234);
    bus(1'b0, OFS_PC, 32'h0);
    chk("pc read only", 32'h0, q);
    bus(1'b1, 5'h02, 32'hff);
    bus(1'b0, 5'h02, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'b0, OFS_WDT, 32'h0);
    chk("wdt idle", 32'h0, q);
    $display("test registers done");
    bus(1'b1, OFS_ACC, 32'h0f);
    acc_m = 8'h0f;
    bus(1'b1, OFS_FADDR, 32'h20);
    bus(1'b1, OFS_FDATA, 32'h81);
    mem[32] = 8'h81;
    port_pins_in <= 8'ha5;
    foreach (PROG[i])
      step(PROG[i]);
    $display("test alu done");
    for (int b = 0; b < 8; b++) begin
      step({4'h5, 3'(b), 7'h7f});
      step({4'h7, 3'(b), 7'h7f});
      step(14'h3e01);
      step({4'h4, 3'(b), 7'h7f});
      step({4'h6, 3'(b), 7'h7f});
      step(14'h3e01);
    end
    $display("test bits done");
    bus(1'b1, OFS_CTRL, 32'h1);
    idle();
    n = 0;
    while (wdt_timeout !== 1'b1 && n < 1500) begin
      n++;
      @(posedge clk);
    end
    chk("timeout seen", 32'h1, {31'h0, n < 1500});
    if (n == 1500)
      report_and_stop();
    st_m[4] = 1'b0;
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("status expired", {27'h0, st_m}, q);
    // Let the counter climb well away from zero before clearing it
    repeat (100)
      idle();
    pc_m++;
    st_m[4:3] = 2'b11;
    bus(1'b1, OFS_INSTR, {18'h0, OPC_WDT_CLR});
    bus(1'b0, OFS_WDT, 32'h0);
    chk("wdt cleared", 32'h0, q);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("status clear", {27'h0, st_m}, q);
    bus(1'b1, OFS_CTRL, 32'h0);
    idle();
    $display("test watchdog done");
    report_and_stop();
  end

  // Cuts a hang short
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
endmodule
